// file: logic/pdod_power_down_and_opendrain_ctrl.sv
// Power-down / reference control and open-drain drive-type registers
`timescale 1ns/1ps
// Summary of operation
// - Global power-down kills reference, all DACs, ADC
// - Otherwise reference and DACs follow individual bits
// - Reference enable powers reference, buffer, drives pin
// - Reference enable clear keeps reference and buffer off
// - Channel bit powers down only DAC-configured channels
// - Cleared channel bit leaves channel operating normally
// - Drive-type bit set gives open-drain, low only
// - Drive-type bit clear gives push/pull output
// - Drive type applies only to selected GPIO outputs
module pdod_power_down_and_opendrain_ctrl (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire pdod_pkg::pdod_req_type request,
	input wire logic [7:0] dacSelect,
	input wire logic [7:0] gpioOutSelect,
	input wire logic [7:0] gpioOutData,
	output logic [15:0] readData,
	output logic readValid,
	output logic referencePowerUp,
	output logic referencePinDrive,
	output logic adcPowerDown,
	output pdod_pkg::pdod_chan_type channelState
);
	// ==========================================================
	// Register storage
	logic [15:0] powerReg_q;
	logic [15:0] powerReg_d;
	logic [15:0] driveReg_q;
	logic [15:0] driveReg_d;
	logic globalPowerDown;
	logic referenceEnable;
	logic writePower;
	logic writeDrive;
	logic [15:0] readMux;
	logic [7:0] dacPowerDownNext;
	logic [7:0] padEnableNext;
	logic [7:0] padLevelNext;

	// Write decode; masking keeps reserved bits at zero
	assign writePower = request.write && (request.select == pdod_pkg::SEL_POWER);
	assign writeDrive = request.write && (request.select == pdod_pkg::SEL_DRIVE);
	assign powerReg_d = writePower ? (request.data & pdod_pkg::POWER_WRITE_MASK) : powerReg_q;
	assign driveReg_d = writeDrive ? (request.data & pdod_pkg::DRIVE_WRITE_MASK) : driveReg_q;

	// Read selection; unmapped selects read as zero
	assign readMux = (request.select == pdod_pkg::SEL_POWER) ? powerReg_q :
		(request.select == pdod_pkg::SEL_DRIVE) ? driveReg_q : 16'h0000;

	// Decoded control fields
	assign globalPowerDown = powerReg_q[pdod_pkg::POS_GLOBAL_PD];
	assign referenceEnable = powerReg_q[pdod_pkg::POS_REF_EN];

	// ==========================================================
	// Per-channel power and pad drive
	genvar ch;
	generate
		for (ch = 0; ch < pdod_pkg::CHANNELS; ch++)
		begin : gChan
			// A clear channel bit leaves the DAC running unless global power-down is set
			assign dacPowerDownNext[ch] = globalPowerDown |
				(powerReg_q[ch] & dacSelect[ch]);
			// Open-drain never drives high, so the enable drops for a one
			assign padEnableNext[ch] = gpioOutSelect[ch] &
				(~driveReg_q[ch] | ~gpioOutData[ch]);
			assign padLevelNext[ch] = gpioOutData[ch] & ~driveReg_q[ch];
		end
	endgenerate

	// Register update
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			powerReg_q <= pdod_pkg::POWER_RESET;
			driveReg_q <= pdod_pkg::DRIVE_RESET;
		end
		else if (clockEnable)
		begin
			powerReg_q <= powerReg_d;
			driveReg_q <= driveReg_d;
		end
	end

	// Read port, answered one cycle after the request
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			readData <= 16'h0000;
			readValid <= 1'b0;
		end
		else if (clockEnable)
		begin
			readValid <= request.read;
			readData <= request.read ? readMux : readData;
		end
	end

	// Registered analog controls; host must keep reference off with an external one
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			referencePowerUp <= 1'b0;
			referencePinDrive <= 1'b0;
			adcPowerDown <= 1'b0;
			channelState <= '0;
		end
		else if (clockEnable)
		begin
			referencePowerUp <= referenceEnable & ~globalPowerDown;
			referencePinDrive <= referenceEnable & ~globalPowerDown;
			adcPowerDown <= globalPowerDown;
			channelState.dacPowerDown <= dacPowerDownNext;
			channelState.padDriveEnable <= padEnableNext;
			channelState.padLevel <= padLevelNext;
		end
	end
endmodule

// file: logic/pdod_pkg.sv
// Package for the power-down and pin drive-type control registers
package pdod_pkg;
	// ==========================================================
	// Register selection and widths
	localparam int REG_WIDTH = 16;
	localparam int CHANNELS = 8;
	localparam logic [1:0] SEL_POWER = 2'h0;
	localparam logic [1:0] SEL_DRIVE = 2'h1;
	// ==========================================================
	// Field positions and reset values
	localparam int POS_GLOBAL_PD = 10;
	localparam int POS_REF_EN = 9;
	localparam logic [15:0] POWER_WRITE_MASK = 16'h06ff;
	localparam logic [15:0] DRIVE_WRITE_MASK = 16'h00ff;
	localparam logic [15:0] POWER_RESET = 16'h0000;
	localparam logic [15:0] DRIVE_RESET = 16'h0000;

	// Register access request from the serial front end
	typedef struct packed {
		logic write;
		logic read;
		logic [1:0] select;
		logic [15:0] data;
	} pdod_req_type;

	// Per-channel state handed to the analog and pad logic
	typedef struct packed {
		logic [7:0] dacPowerDown;
		logic [7:0] padDriveEnable;
		logic [7:0] padLevel;
	} pdod_chan_type;
endpackage

// file: verification/pdod_ctrl_properties.sv
// Checker on the ports of the power-down and drive-type register block
`timescale 1ns/1ps
module pdod_ctrl_checker (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire pdod_pkg::pdod_req_type request,
	input wire logic [15:0] readData,
	input wire logic readValid,
	input wire logic referencePowerUp,
	input wire logic referencePinDrive,
	input wire logic adcPowerDown,
	input wire pdod_pkg::pdod_chan_type channelState
);
	// ==========================================================
	// Port relations; one clock domain
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire powerWrite = clockEnable && request.write && request.select == pdod_pkg::SEL_POWER;
	chk_read_answer: assert property (clockEnable && request.read |=> readValid)
		else $error("read not answered");
	chk_valid_cause: assert property (readValid |-> $past(clockEnable && request.read))
		else $error("stray read answer");
	chk_global_off: assert property (adcPowerDown |-> !referencePowerUp && &channelState.dacPowerDown)
		else $error("global power-down leaks");
	chk_ref_pin: assert property (referencePinDrive == referencePowerUp)
		else $error("reference pin mismatch");
	chk_reserved_read: assert property (readValid |-> readData[15:11] == 5'h00 && !readData[8])
		else $error("reserved bits set");
	chk_global_write: assert property (powerWrite |=> ##1 adcPowerDown == $past(request.data[10], 2))
		else $error("global power-down late");
	chk_ref_write: assert property (powerWrite |=> ##1
		referencePowerUp == ($past(request.data[9], 2) && !$past(request.data[10], 2)))
		else $error("reference state wrong");
	chk_frozen_read: assert property (!clockEnable |=> $stable(readData) && !readValid)
		else $error("moved while frozen");
endmodule
bind pdod_power_down_and_opendrain_ctrl pdod_ctrl_checker u_pdod_ctrl_checker (.*);

// file: verification/pdod_host_model.sv
// Host model issuing register requests
`timescale 1ns/1ps
module pdod_host_model #(parameter bit extRef = 0) (
	input wire logic clock,
	output pdod_pkg::pdod_req_type request
);
	initial request = '0;
	// One strobe per call; an external reference forbids the enable bit
	task automatic xfer(input logic w, input logic [1:0] s, input logic [15:0] d);
		@(negedge clock) request = '{w, !w, s, extRef ? d & 16'hfdff : d};
		@(negedge clock) request = '0;
	endtask
endmodule

// file: verification/tb_pdod_power_down_and_opendrain_ctrl.sv
// Self-checking bench for the power-down and drive-type registers
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module tb_pdod_power_down_and_opendrain_ctrl;
	logic clock = 0, reset = 1, clockEnable = 1, readValid, referencePowerUp, referencePinDrive, adcPowerDown;
	logic [7:0] dacSelect = 8'hff, gpioOutSelect = 8'h00, gpioOutData = 8'h0f;
	logic [15:0] readData;
	int failures = 0, comparisons = 0;
	pdod_pkg::pdod_req_type request;
	pdod_pkg::pdod_chan_type channelState;
	always #2.5 clock = ~clock;
	pdod_host_model u_pdod_host_model (.*);
	pdod_power_down_and_opendrain_ctrl u_pdod_power_down_and_opendrain_ctrl (.*);
	// Write, then one more edge for the output flop
	task automatic wr(input logic [1:0] s, input logic [15:0] d);
		u_pdod_host_model.xfer(1'b1, s, d);
		@(negedge clock);
	endtask
	task automatic rd(input logic [1:0] s, input logic [15:0] e);
		u_pdod_host_model.xfer(1'b0, s, 16'h0000);
		`CHK(readValid, 1'b1)
		`CHK(readData, e)
	endtask
	task automatic stop_test;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// Sequence; reserved bits are written as ones on purpose
	initial
	begin
		repeat (4) @(negedge clock);
		reset = 0;
		rd(pdod_pkg::SEL_POWER, 16'h0000);
		rd(pdod_pkg::SEL_DRIVE, 16'h0000);
		wr(pdod_pkg::SEL_POWER, 16'hffff);
		rd(pdod_pkg::SEL_POWER, 16'h06ff);
		`CHK({adcPowerDown, referencePowerUp, channelState.dacPowerDown}, 10'h2ff)
		`CHK(referencePinDrive, 1'b0)
		wr(pdod_pkg::SEL_POWER, 16'h02a5);
		dacSelect = 8'h0f;
		@(negedge clock);
		`CHK({adcPowerDown, referencePowerUp, channelState.dacPowerDown}, 10'h105)
		`CHK(referencePinDrive, 1'b1)
		gpioOutSelect = 8'hff;
		wr(pdod_pkg::SEL_DRIVE, 16'hffff);
		rd(pdod_pkg::SEL_DRIVE, 16'h00ff);
		`CHK(channelState[15:0], 16'hf000)
		wr(pdod_pkg::SEL_DRIVE, 16'h0000);
		`CHK(channelState[15:0], 16'hff0f)
		gpioOutSelect = 8'h00;
		@(negedge clock);
		`CHK(channelState.padDriveEnable, 8'h00)
		clockEnable = 0;
		u_pdod_host_model.xfer(1'b1, pdod_pkg::SEL_DRIVE, 16'h00ff);
		clockEnable = 1;
		rd(pdod_pkg::SEL_DRIVE, 16'h0000);
		rd(2'h2, 16'h0000);
		stop_test();
	end
	// Watchdog well past the sequence length
	initial
	begin
		#5000;
		failures++;
		stop_test();
	end
endmodule
